// File: pmcs_pkg.sv
// Package for the power-mode and system-clock switch block.
// Assumes a single 125 MHz clock; oscillator status arrives as async levels.
package pmcs_pkg;

   // Register map, byte addresses on the AXI4-Lite slave
   localparam int          AXI_AW       = 4;
   localparam logic [3:0]  PCC_OFFSET   = 4'h0;
   localparam logic [3:0]  TCR_OFFSET   = 4'h4;

   // power_clock_control_reg fields
   localparam int          IDLE_BIT     = 7;
   localparam int          PRUN_BIT     = 3;
   localparam int          ISTAB_BIT    = 2;
   localparam int          SEL_MSB      = 1;
   localparam int          SEL_LSB      = 0;
   // timer_control_reg fields
   localparam int          SEC_ACT_BIT  = 6;
   localparam int          SEC_EN_BIT   = 3;

   // Values after reset
   localparam logic [1:0]  SEL_RST      = 2'h0;
   localparam logic        IDLE_RST     = 1'h0;
   localparam logic        SEC_EN_RST   = 1'h0;
   localparam logic        PRUN_RST     = 1'h1;
   localparam logic [1:0]  BOOT_CYC     = 2'h2;

   // Transition window in clock cycles: outgoing, then incoming
   localparam int          SW_OLD_CYC   = 2;
   localparam int          SW_NEW_CYC   = 4;

   localparam logic [1:0]  RESP_OKAY    = 2'h0;
   localparam logic [1:0]  RESP_SLVERR  = 2'h2;

   typedef enum logic [1:0] {
      SRC_PRI = 2'b00,
      SRC_SEC = 2'b01,
      SRC_INT = 2'b10
   } pmcs_src_e;

   typedef enum logic [1:0] {
      PM_RUN   = 2'b00,
      PM_IDLE  = 2'b01,
      PM_SLEEP = 2'b10
   } pmcs_pm_e;

   typedef enum logic [1:0] {
      SW_REST = 2'b00,
      SW_OLD  = 2'b01,
      SW_NEW  = 2'b10
   } pmcs_sw_e;

   // High bit set means internal block whatever the low bit holds
   function automatic pmcs_src_e pmcs_decode_sel(input logic [1:0] sel);
      if (sel[1])
         return SRC_INT;
      return sel[0] ? SRC_SEC : SRC_PRI;
   endfunction

endpackage

// File: pmcs_sw_if.sv
// Link between the mode controller and the clock switch sequencer.
// Assumes both ends run on the same aclk.
`timescale 1ns/1ps
interface pmcs_sw_if import pmcs_pkg::*; ();
   logic      start;
   pmcs_src_e target;
   pmcs_src_e active;
   logic      busy;
   modport ctl (output start, output target, input active, input busy);
   modport sw  (input start, input target, output active, output busy);
endinterface

// File: pmcs_switch.sv
// Glitch-free source switch sequencer: old-source cycles, then new-source cycles.
// Assumes start is held by the controller until the switch is seen busy.
`timescale 1ns/1ps
module pmcs_switch import pmcs_pkg::*; #(
   parameter int OLD_CYC = SW_OLD_CYC,
   parameter int NEW_CYC = SW_NEW_CYC
) (
   // Clock and reset
   input  logic         aclk,
   input  logic         aresetn,
   // Controller side
   pmcs_sw_if.sw        sw
);

   typedef struct packed {
      pmcs_sw_e  ph;
      logic [2:0] cnt;
      pmcs_src_e act;
      pmcs_src_e tgt;
   } pmcs_swst_s;

   pmcs_swst_s st;
   pmcs_swst_s next_st;

   always_comb begin
      next_st = st;
      case (st.ph)
         SW_REST: begin
            if (sw.start && sw.target != st.act) begin
               next_st.ph  = SW_OLD;
               next_st.tgt = sw.target;
               next_st.cnt = 3'(OLD_CYC - 1);
            end
         end
         SW_OLD: begin
            if (st.cnt == 3'h0) begin
               // Output changes only while held, so no runt pulse escapes
               next_st.ph  = SW_NEW;
               next_st.act = st.tgt;
               next_st.cnt = 3'(NEW_CYC - 1);
            end else begin
               next_st.cnt = st.cnt - 3'h1;
            end
         end
         SW_NEW: begin
            if (st.cnt == 3'h0) begin
               next_st.ph = SW_REST;
            end else begin
               next_st.cnt = st.cnt - 3'h1;
            end
         end
         default: begin
            next_st.ph = SW_REST;
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign sw.active = st.act;
   assign sw.busy   = (st.ph != SW_REST);

   ////////////////////////////////////////////////////////////////////////////
   a_window_len: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(sw.busy) |-> sw.busy [*6] ##1 !sw.busy)
      else $error("switch window not six cycles");
   a_source_moves: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(sw.busy) |-> $stable(sw.active) ##1 $stable(sw.active) ##1 $changed(sw.active))
      else $error("source changed outside its slot");
   c_switch_done: cover property (@(posedge aclk) disable iff (!aresetn)
      $fell(sw.busy));

endmodule

// File: pmcs_top.sv
// Power-mode and system-clock switch controller with AXI4-Lite registers.
// Assumes oscillator status pins are async levels and halt/wake are aclk pulses.
//
// Decided for this implementation: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
module pmcs_top import pmcs_pkg::*; (
   // Clock and reset
   input  logic              aclk,
   input  logic              aresetn,
   // AXI4-Lite write
   input  logic              awvalid,
   output logic              awready,
   input  logic [AXI_AW-1:0] awaddr,
   input  logic              wvalid,
   output logic              wready,
   input  logic [31:0]       wdata,
   input  logic [3:0]        wstrb,
   output logic              bvalid,
   input  logic              bready,
   output logic [1:0]        bresp,
   // AXI4-Lite read
   input  logic              arvalid,
   output logic              arready,
   input  logic [AXI_AW-1:0] araddr,
   output logic              rvalid,
   input  logic              rready,
   output logic [31:0]       rdata,
   output logic [1:0]        rresp,
   // CPU events
   input  logic              halt_exec,
   input  logic              wake_event,
   // Oscillator status and straps, asynchronous
   input  logic              primary_ready_pin,
   input  logic              secondary_running_pin,
   input  logic              internal_stable_pin,
   input  logic              two_speed_en,
   input  logic              primary_osc_config,
   // Clock control
   output logic              primary_osc_en,
   output logic [1:0]        sys_clk_sel,
   output logic              cpu_clk_en,
   output logic              periph_clk_en,
   output logic [1:0]        power_mode
);

   typedef struct packed {
      logic [4:0]  s1;
      logic [4:0]  s2;
      logic [1:0]  boot;
      logic        aw_h;
      logic [3:0]  aw_a;
      logic        w_h;
      logic [7:0]  w_d;
      logic        w_s;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [7:0]  rdata;
      logic [1:0]  rresp;
      logic        idle_on_halt;
      logic [1:0]  clock_source_select;
      logic        secondary_osc_enable;
      pmcs_pm_e    pm;
      logic        primary_clock_running;
      logic        internal_osc_stable;
      logic        secondary_clock_active;
   } pmcs_st_s;

   pmcs_st_s  st;
   pmcs_st_s  next_st;
   pmcs_sw_if swl ();

   logic      pri_rdy;
   logic      secondary_run_mode;
   logic      int_ok;
   logic      two_spd;
   logic      pri_int;
   pmcs_src_e target;
   logic      sel_ok;
   logic      src_ok;
   logic      clk_ok;
   logic      do_write;

   pmcs_switch u_switch (
      .aclk    (aclk),
      .aresetn (aresetn),
      .sw      (swl.sw)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Synchronised pin levels, second stage only
   assign pri_rdy  = st.s2[0];
   assign secondary_run_mode  = st.s2[1];
   assign int_ok   = st.s2[2];
   assign two_spd  = st.s2[3];
   assign pri_int  = st.s2[4];

   assign target   = pmcs_decode_sel(st.clock_source_select);
   assign sel_ok   = (target != SRC_SEC) || st.secondary_osc_enable;
   // Primary must be ready first; meanwhile the old source keeps clocking
   assign swl.start  = (target != swl.active) && sel_ok && (st.pm != PM_SLEEP) &&
                       ((target != SRC_PRI) || pri_rdy);
   assign swl.target = target;

   // Timer osc is trusted once running; early oscillation is the user's risk
   always_comb begin
      case (swl.active)
         SRC_PRI: src_ok = pri_rdy || two_spd;
         SRC_SEC: src_ok = secondary_run_mode;
         default: src_ok = 1'b1;
      endcase
   end

   assign clk_ok        = !swl.busy && src_ok && (st.boot == 2'h0);
   assign cpu_clk_en    = (st.pm == PM_RUN) && clk_ok;
   assign periph_clk_en = (st.pm != PM_SLEEP) && clk_ok;
   assign primary_osc_en = (st.pm != PM_SLEEP) &&
                           (swl.active == SRC_PRI || target == SRC_PRI);
   assign sys_clk_sel   = swl.active;
   assign power_mode    = st.pm;

   assign do_write = st.aw_h && st.w_h && !st.bvalid;

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      next_st    = st;
      next_st.s1 = {primary_osc_config, two_speed_en, internal_stable_pin,
                    secondary_running_pin, primary_ready_pin};
      next_st.s2 = st.s1;
      if (st.boot != 2'h0)
         next_st.boot = st.boot - 2'h1;

      // Write channels are taken in either order
      if (awvalid && !st.aw_h) begin
         next_st.aw_h = 1'b1;
         next_st.aw_a = awaddr;
      end
      if (wvalid && !st.w_h) begin
         next_st.w_h = 1'b1;
         next_st.w_d = wdata[7:0];
         next_st.w_s = wstrb[0];
      end
      if (st.bvalid && bready)
         next_st.bvalid = 1'b0;
      if (do_write) begin
         next_st.aw_h   = 1'b0;
         next_st.w_h    = 1'b0;
         next_st.bvalid = 1'b1;
         next_st.bresp  = RESP_OKAY;
         if (st.aw_a == PCC_OFFSET) begin
            if (st.w_s) begin
               next_st.idle_on_halt        = st.w_d[IDLE_BIT];
               next_st.clock_source_select = st.w_d[SEL_MSB:SEL_LSB];
            end
         end else if (st.aw_a == TCR_OFFSET) begin
            if (st.w_s)
               next_st.secondary_osc_enable = st.w_d[SEC_EN_BIT];
         end else begin
            next_st.bresp = RESP_SLVERR;
         end
      end

      if (st.rvalid && rready)
         next_st.rvalid = 1'b0;
      if (arvalid && !st.rvalid) begin
         next_st.rvalid = 1'b1;
         next_st.rresp  = RESP_OKAY;
         next_st.rdata  = 8'h00;
         if (araddr == PCC_OFFSET) begin
            next_st.rdata[IDLE_BIT]        = st.idle_on_halt;
            next_st.rdata[PRUN_BIT]        = st.primary_clock_running;
            next_st.rdata[ISTAB_BIT]       = st.internal_osc_stable;
            next_st.rdata[SEL_MSB:SEL_LSB] = st.clock_source_select;
         end else if (araddr == TCR_OFFSET) begin
            next_st.rdata[SEC_ACT_BIT] = st.secondary_clock_active;
            next_st.rdata[SEC_EN_BIT]  = st.secondary_osc_enable;
         end else begin
            next_st.rresp = RESP_SLVERR;
         end
      end

      // Halt picks its mode from idle_on_halt as it stands now
      case (st.pm)
         PM_RUN: begin
            if (halt_exec) begin
               if (!st.idle_on_halt)
                  next_st.pm = PM_SLEEP;
               else if (sel_ok)
                  next_st.pm = PM_IDLE;
            end
         end
         PM_IDLE, PM_SLEEP: begin
            if (wake_event)
               next_st.pm = PM_RUN;
         end
         default: begin
            next_st.pm = PM_RUN;
         end
      endcase

      // Flags hold through a switch window, all drop in sleep
      if (st.boot != 2'h0) begin
         next_st.primary_clock_running = st.primary_clock_running;
      end else if (st.pm == PM_SLEEP) begin
         next_st.primary_clock_running  = 1'b0;
         next_st.internal_osc_stable    = 1'b0;
         next_st.secondary_clock_active = 1'b0;
      end else if (!swl.busy) begin
         next_st.primary_clock_running  = (swl.active == SRC_PRI) && pri_rdy;
         next_st.internal_osc_stable    = int_ok && ((swl.active == SRC_INT) ||
                                          (swl.active == SRC_PRI && pri_int));
         next_st.secondary_clock_active = (swl.active == SRC_SEC);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st                       <= '0;
         st.boot                  <= BOOT_CYC;
         st.clock_source_select   <= SEL_RST;
         st.idle_on_halt          <= IDLE_RST;
         st.secondary_osc_enable  <= SEC_EN_RST;
         st.primary_clock_running <= PRUN_RST;
      end else begin
         st <= next_st;
      end
   end

   assign awready = !st.aw_h;
   assign wready  = !st.w_h;
   assign bvalid  = st.bvalid;
   assign bresp   = st.bresp;
   assign arready = !st.rvalid;
   assign rvalid  = st.rvalid;
   assign rdata   = {24'h000000, st.rdata};
   assign rresp   = st.rresp;

   ////////////////////////////////////////////////////////////////////////////
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_halt_to_sleep: assert property (
      halt_exec && st.pm == PM_RUN && !st.idle_on_halt |=> st.pm == PM_SLEEP)
      else $error("halt with idle bit clear did not sleep");
   a_halt_to_idle: assert property (
      halt_exec && st.pm == PM_RUN && st.idle_on_halt && sel_ok |=>
      st.pm == PM_IDLE && !cpu_clk_en)
      else $error("halt with idle bit set did not idle");
   a_sleep_no_clock: assert property (
      st.pm == PM_SLEEP |-> !cpu_clk_en && !periph_clk_en && !primary_osc_en)
      else $error("clock running in sleep");
   a_sleep_flags: assert property (
      st.pm == PM_SLEEP && $past(st.pm) == PM_SLEEP && st.boot == 2'h0 |->
      {st.primary_clock_running, st.internal_osc_stable,
       st.secondary_clock_active} == 3'h0)
      else $error("status flag set in sleep");
   a_sec_refused: assert property (
      target == SRC_SEC && !st.secondary_osc_enable |-> !swl.start)
      else $error("switch to disabled timer osc");
   a_ctrl_kept: assert property (
      !do_write |=> $stable(st.clock_source_select) && $stable(st.idle_on_halt))
      else $error("control bits moved without a write");
   a_gate_window: assert property (
      swl.busy |-> !cpu_clk_en && !periph_clk_en)
      else $error("clock enabled inside switch window");
   a_sec_flag: assert property (
      swl.active == SRC_SEC && !swl.busy && st.pm != PM_SLEEP && st.boot == 2'h0 |=>
      st.secondary_clock_active && !st.primary_clock_running)
      else $error("timer osc flags wrong");
   a_sec_wait: assert property (
      swl.active == SRC_SEC && !secondary_run_mode |-> !cpu_clk_en)
      else $error("clock from stopped timer osc");
   a_int_no_pri: assert property (
      swl.active == SRC_INT && !swl.busy && st.pm != PM_SLEEP && st.boot == 2'h0 |=>
      !st.primary_clock_running)
      else $error("primary flag set on internal source");
   // Two-speed start-up keeps the core running while the primary warms up
   a_two_speed_run: assert property (
      st.pm == PM_RUN && swl.active == SRC_PRI && !swl.busy && st.boot == 2'h0 &&
      two_spd |-> cpu_clk_en)
      else $error("two-speed start-up withheld clock");

   c_sleep: cover property (st.pm == PM_RUN ##1 st.pm == PM_SLEEP ##[1:50] st.pm == PM_RUN);
   c_idle: cover property (st.pm == PM_IDLE ##[1:50] st.pm == PM_RUN);
   c_to_sec: cover property (swl.start && target == SRC_SEC ##[1:20] st.secondary_clock_active);
   c_back_pri: cover property (swl.start && target == SRC_PRI && swl.active == SRC_SEC);

endmodule

// File: pmcs_tb.sv
// Self-checking bench for the power-mode and clock switch block.
// Assumes pmcs_pkg and pmcs_top are compiled first; the bench acts as AXI4-Lite master.
`timescale 1ns/1ps
module testbench;
   import pmcs_pkg::*;

   logic              aclk;
   logic              aresetn;
   logic              awvalid, awready, wvalid, wready, bvalid, bready;
   logic [AXI_AW-1:0] awaddr, araddr;
   logic [31:0]       wdata, rdata;
   logic [3:0]        wstrb;
   logic [1:0]        bresp, rresp;
   logic              arvalid, arready, rvalid, rready;
   logic              halt_exec, wake_event;
   logic              primary_ready_pin, secondary_running_pin, internal_stable_pin;
   logic              two_speed_en, primary_osc_config;
   logic              primary_osc_en, cpu_clk_en, periph_clk_en;
   logic [1:0]        sys_clk_sel, power_mode;
   int                n_fail, num_checks, cyc, low_run, last_low;

   pmcs_top pmcs_top_i (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
      .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
      .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
      .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
      .halt_exec(halt_exec), .wake_event(wake_event), .primary_ready_pin(primary_ready_pin),
      .secondary_running_pin(secondary_running_pin), .internal_stable_pin(internal_stable_pin),
      .two_speed_en(two_speed_en), .primary_osc_config(primary_osc_config),
      .primary_osc_en(primary_osc_en), .sys_clk_sel(sys_clk_sel), .cpu_clk_en(cpu_clk_en),
      .periph_clk_en(periph_clk_en), .power_mode(power_mode));

   ////////////////////////////////////////////////////////////////////////////////
   initial aclk = 1'b0;
   always #4 aclk = ~aclk;

   // Length of the last gap in CPU clocking, sampled mid-cycle
   always @(negedge aclk) begin
      if (cpu_clk_en !== 1'b1) begin
         low_run++;
      end else if (low_run != 0) begin
         last_low = low_run;
         low_run = 0;
      end
   end

   always @(posedge aclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         results();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic results();
      if (n_fail == 0 && num_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Ready is looked at mid-cycle, so the value seen is the one the next edge samples
   task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
      bit ad, wd, ta, tw, got;
      ad = 0;
      wd = 0;
      got = 0;
      @(posedge aclk);
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      awaddr  <= a;
      wdata   <= d;
      bready  <= 1'b1;
      while (!(ad && wd)) begin
         @(negedge aclk);
         ta = !ad && awready === 1'b1;
         tw = !wd && wready === 1'b1;
         @(posedge aclk);
         if (ta) begin
            awvalid <= 1'b0;
            ad = 1;
         end
         if (tw) begin
            wvalid <= 1'b0;
            wd = 1;
         end
      end
      while (!got) begin
         @(negedge aclk);
         got = bvalid === 1'b1;
         r = bresp;
         @(posedge aclk);
      end
      bready <= 1'b0;
   endtask

   task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
      bit got;
      got = 0;
      @(posedge aclk);
      arvalid <= 1'b1;
      araddr  <= a;
      rready  <= 1'b1;
      while (!got) begin
         @(negedge aclk);
         got = arready === 1'b1;
         @(posedge aclk);
      end
      arvalid <= 1'b0;
      got = 0;
      while (!got) begin
         @(negedge aclk);
         got = rvalid === 1'b1;
         d = rdata;
         r = rresp;
         @(posedge aclk);
      end
      rready <= 1'b0;
   endtask

   task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
      logic [31:0] d;
      logic [1:0]  r;
      axi_rd(a, d, r);
      chk(d, exp);
      chk(32'(r), 32'(RESP_OKAY));
   endtask

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      logic [1:0] r;
      axi_wr(a, d, r);
      chk(32'(r), 32'(RESP_OKAY));
   endtask

   task automatic pulse(input bit is_halt);
      @(posedge aclk);
      if (is_halt) halt_exec <= 1'b1;
      else wake_event <= 1'b1;
      @(posedge aclk);
      halt_exec  <= 1'b0;
      wake_event <= 1'b0;
      @(negedge aclk);
   endtask

   task automatic wait_sel(input logic [1:0] exp);
      repeat (40) begin
         @(negedge aclk);
         if (sys_clk_sel === exp) break;
      end
      chk(32'(sys_clk_sel), 32'(exp));
   endtask

   task automatic wait_clk();
      repeat (20) begin
         @(negedge aclk);
         if (cpu_clk_en === 1'b1) break;
      end
      chk(32'({cpu_clk_en, periph_clk_en}), 32'h3);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      chk(32'(power_mode), 32'(PM_RUN));
      chk(32'(sys_clk_sel), 32'(SRC_PRI));
      rd_chk(PCC_OFFSET, 32'h08);
      rd_chk(TCR_OFFSET, 32'h00);
   endtask

   task automatic t_unmapped();
      logic [31:0] d;
      logic [1:0]  r;
      axi_wr(4'h8, 32'hFF, r);
      chk(32'(r), 32'(RESP_SLVERR));
      axi_rd(4'h8, d, r);
      chk(32'(r), 32'(RESP_SLVERR));
      chk(d, 32'h0);
      rd_chk(PCC_OFFSET, 32'h08);
   endtask

   task automatic t_modes();
      pulse(1);
      chk(32'({power_mode, cpu_clk_en, periph_clk_en}), {28'h0, PM_SLEEP, 2'b00});
      repeat (2) @(negedge aclk);
      rd_chk(PCC_OFFSET, 32'h00);
      pulse(0);
      chk(32'(power_mode), 32'(PM_RUN));
      wait_clk();
      wr(PCC_OFFSET, 32'h80);
      pulse(1);
      chk(32'({power_mode, cpu_clk_en, periph_clk_en}), {28'h0, PM_IDLE, 2'b01});
      rd_chk(PCC_OFFSET, 32'h88);
      pulse(0);
      wait_clk();
      rd_chk(PCC_OFFSET, 32'h88);
      wr(PCC_OFFSET, 32'h00);
      pulse(1);
      chk(32'(power_mode), 32'(PM_SLEEP));
      pulse(0);
      wait_clk();
      repeat (4) @(negedge aclk);
      rd_chk(PCC_OFFSET, 32'h08);
   endtask

   task automatic t_secondary();
      wr(PCC_OFFSET, 32'h01);
      repeat (20) @(negedge aclk);
      chk(32'({sys_clk_sel, cpu_clk_en}), {29'h0, SRC_PRI, 1'b1});
      wr(TCR_OFFSET, 32'h08);
      wait_sel(SRC_SEC);
      wait_clk();
      chk(32'(primary_osc_en), 32'h0);
      repeat (3) @(negedge aclk);
      chk(32'(last_low), 32'(SW_OLD_CYC + SW_NEW_CYC));
      rd_chk(PCC_OFFSET, 32'h01);
      rd_chk(TCR_OFFSET, 32'h48);
   endtask

   task automatic t_back();
      @(posedge aclk);
      primary_ready_pin <= 1'b0;
      wr(PCC_OFFSET, 32'h00);
      repeat (20) @(negedge aclk);
      chk(32'({sys_clk_sel, cpu_clk_en}), {29'h0, SRC_SEC, 1'b1});
      chk(32'(primary_osc_en), 32'h1);
      @(posedge aclk);
      primary_ready_pin <= 1'b1;
      wait_sel(SRC_PRI);
      wait_clk();
      repeat (3) @(negedge aclk);
      rd_chk(TCR_OFFSET, 32'h08);
      rd_chk(PCC_OFFSET, 32'h08);
   endtask

   task automatic t_internal();
      @(posedge aclk);
      primary_osc_config <= 1'b1;
      repeat (6) @(negedge aclk);
      rd_chk(PCC_OFFSET, 32'h0C);
      wr(PCC_OFFSET, 32'h03);
      wait_sel(SRC_INT);
      wait_clk();
      repeat (3) @(negedge aclk);
      chk(32'(primary_osc_en), 32'h0);
      rd_chk(PCC_OFFSET, 32'h07);
   endtask

   // Timer osc selected before it oscillates, then two-speed start-up
   task automatic t_late();
      @(posedge aclk);
      secondary_running_pin <= 1'b0;
      wr(PCC_OFFSET, 32'h01);
      wait_sel(SRC_SEC);
      repeat (10) @(negedge aclk);
      chk(32'({cpu_clk_en, periph_clk_en}), 32'h0);
      @(posedge aclk);
      secondary_running_pin <= 1'b1;
      wait_clk();
      wr(PCC_OFFSET, 32'h00);
      wait_sel(SRC_PRI);
      @(posedge aclk);
      two_speed_en      <= 1'b1;
      primary_ready_pin <= 1'b0;
      repeat (6) @(negedge aclk);
      chk(32'(cpu_clk_en), 32'h1);
      rd_chk(PCC_OFFSET, 32'h04);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      n_fail = 0;
      num_checks = 0;
      cyc = 0;
      low_run = 0;
      last_low = 0;
      aresetn = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready, halt_exec, wake_event} = '0;
      awaddr = '0;
      araddr = '0;
      wdata = '0;
      wstrb = 4'hF;
      primary_ready_pin = 1'b1;
      secondary_running_pin = 1'b1;
      internal_stable_pin = 1'b1;
      two_speed_en = 1'b0;
      primary_osc_config = 1'b0;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (6) @(negedge aclk);
      t_reset();
      t_unmapped();
      t_modes();
      t_secondary();
      t_back();
      t_internal();
      t_late();
      results();
   end
endmodule
